// file: src/tmr_consts.svh
// Register indices, field positions, reset values and divider masks
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// Register indices; byte address is four times the index
`define TMR_IDX_CMPB    8'h17
`define TMR_IDX_CMPA    8'h18
`define TMR_IDX_CNT     8'h19
`define TMR_IDX_CMC     8'h1a
`define TMR_IDX_OMC     8'h1b
`define TMR_IDX_FLG     8'h39
`define TMR_IDX_DIR     8'h3c

// Field positions
`define TMR_COMA        7:6
`define TMR_COMB        5:4
`define TMR_WF          1:0
`define TMR_FOCA        7
`define TMR_FOCB        6
`define TMR_HB          3
`define TMR_CS          2:0
`define TMR_F_CMPA      0
`define TMR_F_OVF       1
`define TMR_F_CMPB      2

// Values
`define TMR_RST8        8'h00
`define TMR_MAX         8'hff
`define TMR_BOTTOM      8'h00
`define TMR_ONE         8'h01

// Prescaler tap masks
`define TMR_PS8         10'h007
`define TMR_PS64        10'h03f
`define TMR_PS256       10'h0ff
`define TMR_PS1024      10'h3ff

`endif

// file: src/tmr_pkg.sv
// Types shared by the timer files
package tmr_pkg;

  typedef enum logic [2:0] {
    tmr_normal  = 3'h0,
    tmr_pc_ff   = 3'h1,
    tmr_ctc     = 3'h2,
    tmr_fast_ff = 3'h3,
    tmr_rsv4    = 3'h4,
    tmr_pc_a    = 3'h5,
    tmr_rsv6    = 3'h6,
    tmr_fast_a  = 3'h7
  } tmr_mode_t;

  typedef enum logic [2:0] {
    tmr_cs_stop = 3'h0,
    tmr_cs_d1   = 3'h1,
    tmr_cs_d8   = 3'h2,
    tmr_cs_d64  = 3'h3,
    tmr_cs_d256 = 3'h4,
    tmr_cs_d1k  = 3'h5,
    tmr_cs_fall = 3'h6,
    tmr_cs_rise = 3'h7
  } tmr_clksel_t;

endpackage : tmr_pkg

// file: src/tmr_presc.sv
// Prescaler and external pin edge detector giving the timer clock enable
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_presc (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Selection and pin
  input  wire logic [2:0] clock_select_i,
  input  wire logic       ext_pin_i,
  // Enable
  output logic            timer_clock_enable_o
);

  logic [9:0] div_reg;
  logic [2:0] sync_reg;
  logic       tick;
  wire  logic rise_w = sync_reg[1] & ~sync_reg[2];
  wire  logic fall_w = ~sync_reg[1] & sync_reg[2];

  // Free-running divider; taps share it so they stay phase related
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_reg  <= 10'h000;
      sync_reg <= 3'h0;
    end
    else
    begin
      div_reg  <= div_reg + 10'h001;
      sync_reg <= {sync_reg[1:0], ext_pin_i};
    end
  end

  always_comb
  begin
    tick = 1'b0;
    unique case (tmr_pkg::tmr_clksel_t'(clock_select_i))
      tmr_pkg::tmr_cs_stop: tick = 1'b0;
      tmr_pkg::tmr_cs_d1:   tick = 1'b1;
      tmr_pkg::tmr_cs_d8:   tick = (div_reg & `TMR_PS8) == `TMR_PS8;
      tmr_pkg::tmr_cs_d64:  tick = (div_reg & `TMR_PS64) == `TMR_PS64;
      tmr_pkg::tmr_cs_d256: tick = (div_reg & `TMR_PS256) == `TMR_PS256;
      tmr_pkg::tmr_cs_d1k:  tick = div_reg == `TMR_PS1024;
      tmr_pkg::tmr_cs_fall: tick = fall_w;
      tmr_pkg::tmr_cs_rise: tick = rise_w;
    endcase
  end

  assign timer_clock_enable_o = tick;

endmodule : tmr_presc

// file: src/tmr_top.sv
// 8-bit timer/counter with two waveform channels and Avalon-MM registers
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "tmr_consts.svh"
////////////////////////////////////////////////////////////////////////////
module tmr_top (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // External count pin and vector acknowledges
  input  wire logic        ext_clk_pin_i,
  input  wire logic        vec_ack_ovf_i,
  input  wire logic        vec_ack_cmp_a_i,
  input  wire logic        vec_ack_cmp_b_i,
  // Waveform pins
  output logic             wave_out_a_o,
  output logic             wave_out_b_o,
  output logic             wave_oe_a_o,
  output logic             wave_oe_b_o,
  output logic             wave_sel_a_o,
  output logic             wave_sel_b_o,
  // Flags
  output logic             overflow_flag_o,
  output logic             compare_flag_a_o,
  output logic             compare_flag_b_o
);

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [1:0]      coma_reg;
  logic [1:0]      comb_reg;
  logic [1:0]      wf_reg;
  logic            hb_reg;
  logic [2:0]      cs_reg;
  logic [1:0]      dir_reg;
  logic [7:0]      cnt_reg;
  logic [7:0]      cnt_next;
  logic            up_reg;
  logic            up_next;
  logic            blk_reg;
  logic            tov_reg;
  logic [1:0]      ocf_reg;
  logic [1:0][7:0] buf_reg;
  logic [1:0][7:0] act_reg;
  logic [1:0]      wave_reg;
  logic [1:0]      wave_next;
  logic [1:0]      sel_reg;
  logic [1:0]      oe_reg;
  logic            wait_reg;
  logic [7:0]      rdata_reg;
  logic            tick_w;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic [7:0] wd = avs_writedata_i[7:0];
  wire logic wr_go = avs_write_i & ~wait_reg & avs_byteenable_i[0];
  wire logic hit_omc  = avs_address_i == {`TMR_IDX_OMC, 2'b00};
  wire logic hit_cmc  = avs_address_i == {`TMR_IDX_CMC, 2'b00};
  wire logic hit_cnt  = avs_address_i == {`TMR_IDX_CNT, 2'b00};
  wire logic hit_cmpa = avs_address_i == {`TMR_IDX_CMPA, 2'b00};
  wire logic hit_cmpb = avs_address_i == {`TMR_IDX_CMPB, 2'b00};
  wire logic hit_flg  = avs_address_i == {`TMR_IDX_FLG, 2'b00};
  wire logic hit_dir  = avs_address_i == {`TMR_IDX_DIR, 2'b00};
  wire logic w_omc = wr_go & hit_omc;
  wire logic w_cmc = wr_go & hit_cmc;
  wire logic w_cnt = wr_go & hit_cnt;
  wire logic w_flg = wr_go & hit_flg;
  wire logic w_dir = wr_go & hit_dir;
  wire logic [1:0] w_cmp = {wr_go & hit_cmpb, wr_go & hit_cmpa};

  // Reserved and strobe bits are never stored, so they read zero
  wire logic [7:0] rd_mux =
    hit_omc  ? {coma_reg, comb_reg, 2'b00, wf_reg} :
    hit_cmc  ? {4'h0, hb_reg, cs_reg} :
    hit_cnt  ? cnt_reg :
    hit_cmpa ? buf_reg[0] :
    hit_cmpb ? buf_reg[1] :
    hit_flg  ? {5'h00, ocf_reg[1], tov_reg, ocf_reg[0]} :
    hit_dir  ? {6'h00, dir_reg} : `TMR_RST8;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire tmr_pkg::tmr_mode_t mode_w = tmr_pkg::tmr_mode_t'({hb_reg, wf_reg});
  // Reserved codes 4 and 6 run like normal and clear-on-match
  wire logic pwm_w   = wf_reg[0];
  wire logic fast_w  = wf_reg == 2'b11;
  wire logic phase_w = wf_reg == 2'b01;
  wire logic a_top_w = (wf_reg == 2'b10) | (hb_reg & pwm_w);
  wire logic [7:0] top_w = a_top_w ? act_reg[0] : `TMR_MAX;
  wire logic at_top  = cnt_reg == top_w;
  wire logic at_bot  = cnt_reg == `TMR_BOTTOM;
  wire logic up_w    = up_reg | at_bot;   // A BOTTOM match opens the up slope
  wire logic bot_ev  = tick_w & fast_w & at_top;
  wire logic pc_top  = tick_w & phase_w & up_reg & at_top;
  wire logic upd_w   = phase_w ? pc_top : bot_ev;
  wire logic ovf_ev  = tick_w & (phase_w ? ~up_reg & at_bot :
    (mode_w == tmr_pkg::tmr_fast_a) ? at_top : cnt_reg == `TMR_MAX);
  wire logic [1:0] match_w = {
    tick_w & ~blk_reg & (cnt_reg == act_reg[1]),
    tick_w & ~blk_reg & (cnt_reg == act_reg[0])};
  wire logic [1:0] force_w = {
    w_cmc & wd[`TMR_FOCB] & ~pwm_w,
    w_cmc & wd[`TMR_FOCA] & ~pwm_w};
  wire logic [1:0] clr_w = {
    (w_flg & wd[`TMR_F_CMPB]) | vec_ack_cmp_b_i,
    (w_flg & wd[`TMR_F_CMPA]) | vec_ack_cmp_a_i};
  wire logic clr_ovf = (w_flg & wd[`TMR_F_OVF]) | vec_ack_ovf_i;
  wire logic [1:0][1:0] com_w = {comb_reg, coma_reg};

  ////////////////////////////////////////////////////////////////////////
  // Prescaler
  tmr_presc u_presc (
    .core_clk_i           (core_clk_i),
    .rst_i                (rst_i),
    .clock_select_i       (cs_reg),
    .ext_pin_i            (ext_clk_pin_i),
    .timer_clock_enable_o (tick_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counter
  always_comb
  begin
    cnt_next = cnt_reg;
    up_next  = up_reg;
    if (tick_w)
    begin
      if (!phase_w)
        cnt_next = at_top ? `TMR_BOTTOM : cnt_reg + `TMR_ONE;
      else if (up_reg & at_top)
      begin
        up_next  = 1'b0;
        cnt_next = at_bot ? cnt_reg : cnt_reg - `TMR_ONE;
      end
      else if (!up_reg & at_bot)
      begin
        up_next  = 1'b1;
        cnt_next = cnt_reg + `TMR_ONE;
      end
      else
        cnt_next = up_reg ? cnt_reg + `TMR_ONE : cnt_reg - `TMR_ONE;
    end
    // A software write wins over counting in the same cycle
    if (w_cnt)
      cnt_next = wd;
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveform channels
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    wire logic tgl_ok = (ch == 0) & hb_reg;
    wire logic spec = com_w[ch][1] & (act_reg[ch] == top_w);
    wire logic pc_ev = spec ? pc_top : match_w[ch];
    wire logic [1:0] com = com_w[ch];
    wire logic conn =
      (com != 2'b00) & ~(pwm_w & (com == 2'b01) & ~tgl_ok);

    always_comb
    begin
      wave_next[ch] = wave_reg[ch];
      if (!pwm_w)
      begin
        if (match_w[ch] | force_w[ch])
          wave_next[ch] = (com == 2'b01) ? ~wave_reg[ch] :
            (com[1] ? com[0] : wave_reg[ch]);
      end
      else if (fast_w)
      begin
        if (match_w[ch] & ~spec)
          wave_next[ch] = com[1] ? com[0] :
            ((com[0] & tgl_ok) ? ~wave_reg[ch] : wave_reg[ch]);
        if (bot_ev & com[1])
          wave_next[ch] = ~com[0];
      end
      else if (pc_ev)
        wave_next[ch] = com[1] ? ((up_w & ~spec) ? com[0] : ~com[0]) :
          ((com[0] & tgl_ok) ? ~wave_reg[ch] : wave_reg[ch]);
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        wave_reg[ch] <= 1'b0;
        sel_reg[ch]  <= 1'b0;
        oe_reg[ch]   <= 1'b0;
        ocf_reg[ch]  <= 1'b0;
        buf_reg[ch]  <= `TMR_RST8;
        act_reg[ch]  <= `TMR_RST8;
      end
      else
      begin
        wave_reg[ch] <= wave_next[ch];
        sel_reg[ch]  <= conn;
        oe_reg[ch]   <= conn & dir_reg[ch];
        // Set wins over a clear arriving in the same cycle
        ocf_reg[ch]  <= match_w[ch] | (ocf_reg[ch] & ~clr_w[ch]);
        if (w_cmp[ch])
          buf_reg[ch] <= wd;
        if (w_cmp[ch] & ~pwm_w)
          act_reg[ch] <= wd;
        else if (~pwm_w | upd_w)
          act_reg[ch] <= buf_reg[ch];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers and counter state
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      coma_reg <= 2'h0;
      comb_reg <= 2'h0;
      wf_reg   <= 2'h0;
      hb_reg   <= 1'b0;
      cs_reg   <= 3'h0;
      dir_reg  <= 2'h0;
      cnt_reg  <= `TMR_RST8;
      up_reg   <= 1'b1;
      blk_reg  <= 1'b0;
      tov_reg  <= 1'b0;
    end
    else
    begin
      if (w_omc)
      begin
        coma_reg <= wd[`TMR_COMA];
        comb_reg <= wd[`TMR_COMB];
        wf_reg   <= wd[`TMR_WF];
      end
      if (w_cmc)
      begin
        hb_reg <= wd[`TMR_HB];
        cs_reg <= wd[`TMR_CS];
      end
      if (w_dir)
        dir_reg <= wd[1:0];
      cnt_reg <= cnt_next;
      up_reg  <= up_next;
      blk_reg <= w_cnt | (blk_reg & ~tick_w);
      tov_reg <= ovf_ev | (tov_reg & ~clr_ovf);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, then data and release together
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_reg  <= 1'b1;
      rdata_reg <= `TMR_RST8;
    end
    else
    begin
      wait_reg  <= ~((avs_read_i | avs_write_i) & wait_reg);
      if (avs_read_i & wait_reg)
        rdata_reg <= rd_mux;
    end
  end

  assign avs_readdata_o    = {24'h000000, rdata_reg};
  assign avs_waitrequest_o = wait_reg;
  assign wave_out_a_o      = wave_reg[0];
  assign wave_out_b_o      = wave_reg[1];
  assign wave_oe_a_o       = oe_reg[0];
  assign wave_oe_b_o       = oe_reg[1];
  assign wave_sel_a_o      = sel_reg[0];
  assign wave_sel_b_o      = sel_reg[1];
  assign overflow_flag_o   = tov_reg;
  assign compare_flag_a_o  = ocf_reg[0];
  assign compare_flag_b_o  = ocf_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_pin_disconnect: assert property (
    (coma_reg == 2'b00) |=> !wave_sel_a_o && !wave_oe_a_o)
    else $error("channel A pin driven while disconnected");

  a_nonpwm_set: assert property (
    (!pwm_w && match_w[0] && coma_reg == 2'b11) |=> wave_out_a_o)
    else $error("non-PWM set action missing");

  a_fast_bottom: assert property (
    (bot_ev && comb_reg == 2'b10) |=> wave_out_b_o)
    else $error("fast PWM bottom set missing");

  a_b_no_toggle: assert property (
    (pwm_w && comb_reg == 2'b01) |=> $stable(wave_out_b_o))
    else $error("channel B toggled in PWM");

  a_ovf_max: assert property (
    (tick_w && !pwm_w && cnt_reg == `TMR_MAX) |=> overflow_flag_o)
    else $error("overflow not set at MAX");

  a_ctc_clear: assert property (
    (mode_w == tmr_pkg::tmr_ctc && match_w[0] && !w_cnt)
    |=> cnt_reg == `TMR_BOTTOM && compare_flag_a_o)
    else $error("clear-on-match failed");

  a_flag_cause: assert property (
    $rose(compare_flag_a_o) |-> $past(match_w[0]))
    else $error("compare flag set without match");

  a_tick_only: assert property (
    (!tick_w && !w_cnt) |=> $stable(cnt_reg))
    else $error("counter moved without enable");

  a_write_block: assert property (
    w_cnt |=> match_w == 2'b00)
    else $error("match after counter write");

  a_rsv_read: assert property (
    (avs_read_i && !avs_waitrequest_o && (hit_omc || hit_cmc))
    |-> avs_readdata_o[3:2] == 2'b00 || hit_cmc
        && avs_readdata_o[7:4] == 4'h0)
    else $error("reserved or strobe bits read nonzero");

  a_bus_answer: assert property (
    (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus answer late");

endmodule : tmr_top

// file: tb/tmr_pin_load.sv
// Load on the two waveform pins, with port pull-ups where nothing drives
`timescale 1ns/100ps
module tmr_pin_load (
  // Pin drivers
  input  wire logic wave_a_i,
  input  wire logic wave_b_i,
  input  wire logic oe_a_i,
  input  wire logic oe_b_i,
  // Pin levels seen outside
  output logic      pin_a_o,
  output logic      pin_b_o
);
  // An undriven pin floats to its pull-up, never to the last value
  assign pin_a_o = oe_a_i ? wave_a_i : 1'b1;
  assign pin_b_o = oe_b_i ? wave_b_i : 1'b1;
endmodule : tmr_pin_load

// file: tb/tb.sv
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tb;
  logic        core_clk_i;
  logic        rst_i;
  logic [9:0]  adr;
  logic        rd_q;
  logic        wr_q;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wait_q;
  logic        ext_pin;
  logic [2:0]  ack;
  logic        wa, wb, oea, oeb, sela, selb, ovf, cfa, cfb;
  logic        pin_a, pin_b;
  logic        ea;
  int          mismatches;
  int          n_checks;
  int          seed;
  int          ha, hb, ta, ca, cb;
  int          cs_q[$] = '{1, 2, 3, 4, 5, 6, 7};
  int          dv_q[$] = '{1, 8, 64, 256, 1024, 8, 8};
  int          fm_q[$] = '{1, 2, 3, 1};

  tmr_top tmr_top_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_q), .ext_clk_pin_i(ext_pin),
    .vec_ack_ovf_i(ack[0]), .vec_ack_cmp_a_i(ack[1]),
    .vec_ack_cmp_b_i(ack[2]), .wave_out_a_o(wa), .wave_out_b_o(wb),
    .wave_oe_a_o(oea), .wave_oe_b_o(oeb), .wave_sel_a_o(sela),
    .wave_sel_b_o(selb), .overflow_flag_o(ovf),
    .compare_flag_a_o(cfa), .compare_flag_b_o(cfb));

  tmr_pin_load tmr_pin_load_inst (
    .wave_a_i(wa), .wave_b_i(wb), .oe_a_i(oea), .oe_b_i(oeb),
    .pin_a_o(pin_a), .pin_b_o(pin_b));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // External count pin: one rising and one falling edge every 8 cycles
  initial
  begin
    ext_pin = 1'b0;
    forever #40 ext_pin = ~ext_pin;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    wr_q <= w;
    rd_q <= ~w;
    // No cycle count assumed; only the watchdog ends a hung request
    do
      @(posedge core_clk_i);
    while (wait_q !== 1'b0);
    q = rdat;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] idx,
                      input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(what, q, {24'h0, e});
  endtask : rchk

  // High cycles of both outputs and toggles of output A over n cycles
  task automatic measure(input int n);
    logic last;
    ha = 0;
    hb = 0;
    ta = 0;
    @(posedge core_clk_i);
    last = wa;
    repeat (n)
    begin
      @(posedge core_clk_i);
      ha += (wa === 1'b1);
      hb += (wb === 1'b1);
      ta += (wa !== last);
      last = wa;
    end
  endtask : measure

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    #800_000;
    mismatches++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 10;
    rst_i = 1'b1;
    adr = 10'h000;
    rd_q = 1'b0;
    wr_q = 1'b0;
    wdat = 32'h0;
    ack = 3'h0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    check("reset pins", {wa, wb, sela, selb, oea, oeb, ovf, cfa, cfb},
          0);
    rchk("omc reset", `TMR_IDX_OMC, 8'h00);
    rchk("cmc reset", `TMR_IDX_CMC, 8'h00);
    $display("test reset done");
    // Reserved bits, strobes, force ignored in a PWM mode
    wr(`TMR_IDX_OMC, 8'hff);
    rchk("omc read", `TMR_IDX_OMC, 8'hf3);
    wr(`TMR_IDX_CMC, 8'hf8);
    rchk("cmc read", `TMR_IDX_CMC, 8'h08);
    check("pwm force", {wa, wb}, 0);
    rchk("unmapped", 8'h01, 8'h00);
    wr(`TMR_IDX_CMC, 8'h00);
    wr(`TMR_IDX_OMC, 8'h53);
    repeat (2) @(posedge core_clk_i);
    check("pwm 01 sel", {sela, selb}, 0);
    $display("test registers done");
    // Forced matches in normal mode, output mode taken at the strobe
    ea = 1'b0;
    foreach (fm_q[i])
    begin
      wr(`TMR_IDX_OMC, {fm_q[i][1:0], fm_q[i][1:0], 4'h0});
      wr(`TMR_IDX_CMC, 8'hc0);
      ea = (fm_q[i] == 1) ? ~ea : (fm_q[i] == 3);
      @(posedge core_clk_i);
      check("force out", {wa, wb}, {ea, ea});
      check("force flags", {cfa, cfb, ovf, sela, selb},
            5'h03);
    end
    wr(`TMR_IDX_DIR, 8'h03);
    repeat (2) @(posedge core_clk_i);
    check("pin drive", {oea, oeb, pin_a, pin_b}, {2'b11, ea, ea});
    wr(`TMR_IDX_DIR, 8'h01);
    repeat (2) @(posedge core_clk_i);
    check("pin release", {oea, oeb, pin_a, pin_b},
          {2'b10, ea, 1'b1});
    $display("test force done");
    // Clear-on-match toggling at every clock selection except stop
    wr(`TMR_IDX_CMPA, 8'h05);
    wr(`TMR_IDX_OMC, 8'h42);
    foreach (cs_q[i])
    begin
      wr(`TMR_IDX_CMC, cs_q[i][7:0]);
      repeat (12 * dv_q[i] + 4) @(posedge core_clk_i);
      // Slowest divider gets a short window to keep the run bounded
      measure(((cs_q[i] == 5) ? 12 : 60) * dv_q[i]);
      check("ctc toggles", ta,
            (cs_q[i] == 5) ? 2 : 10);
    end
    wr(`TMR_IDX_CMC, 8'h00);
    rchk("ctc flags", `TMR_IDX_FLG, 8'h05);
    wr(`TMR_IDX_FLG, 8'h05);
    rchk("flag clear", `TMR_IDX_FLG, 8'h00);
    $display("test clear on match done");
    // Overflow at MAX in normal mode, cleared by the vector
    wr(`TMR_IDX_CMPA, 8'h80);
    wr(`TMR_IDX_CMPB, 8'h80);
    wr(`TMR_IDX_OMC, 8'h00);
    wr(`TMR_IDX_CNT, 8'hfa);
    wr(`TMR_IDX_CMC, 8'h01);
    repeat (8) @(posedge core_clk_i);
    wr(`TMR_IDX_CMC, 8'h00);
    rchk("ovf flag", `TMR_IDX_FLG, 8'h02);
    ack <= 3'h1;
    @(posedge core_clk_i);
    ack <= 3'h0;
    rchk("ovf ack", `TMR_IDX_FLG, 8'h00);
    $display("test overflow done");
    // Duty of phase correct and fast PWM, first round at TOP
    for (int k = 0; k < 3; k++)
    begin
      ca = (k == 0) ? 255 : ($random(seed) & 8'hff);
      cb = (k == 0) ? 255 : ($random(seed) & 8'hff);
      wr(`TMR_IDX_CMPA, ca[7:0]);
      wr(`TMR_IDX_CMPB, cb[7:0]);
      wr(`TMR_IDX_OMC, 8'he1);
      wr(`TMR_IDX_CMC, 8'h01);
      repeat (1100) @(posedge core_clk_i);
      measure(510);
      check("phase a", ha, 510 - 2 * ca);
      check("phase b", hb, 2 * cb);
      wr(`TMR_IDX_OMC, 8'he3);
      repeat (600) @(posedge core_clk_i);
      measure(256);
      check("fast a", ha, 255 - ca);
      check("fast b", hb, cb + 1);
    end
    $display("test pwm duty done");
    // Fast PWM with compare A as TOP
    wr(`TMR_IDX_CMPA, 8'h09);
    wr(`TMR_IDX_CMPB, 8'h03);
    wr(`TMR_IDX_OMC, 8'h23);
    wr(`TMR_IDX_FLG, 8'h07);
    wr(`TMR_IDX_CMC, 8'h09);
    // New TOP only lands at the next wrap, at 0xff or at the old compare A TOP
    repeat (300) @(posedge core_clk_i);
    measure(100);
    check("top a duty", hb, 40);
    wr(`TMR_IDX_CMC, 8'h08);
    rchk("top flags", `TMR_IDX_FLG, 8'h07);
    // Phase PWM with compare A as TOP; channel A toggles at each match
    wr(`TMR_IDX_OMC, 8'h61);
    wr(`TMR_IDX_CMC, 8'h09);
    repeat (50) @(posedge core_clk_i);
    measure(180);
    check("phase top b", hb, 60);
    check("phase toggle a", ta, 10);
    wr(`TMR_IDX_CMC, 8'h00);
    $display("test compare top done");
    give_verdict();
  end
endmodule : tb
